// ===== pds_pkg.sv
package pds_pkg;
   // Stage count and scan index limits
   localparam int NSTG = 20;
   localparam logic [4:0] LAST_STG = 5'h13;

   // Clock rate and one-second prescaler
   localparam int CLK_HZ = 20_000_000;
   localparam int SEC_TIME_S = 1;
   localparam int SEC_CYC_DEF = CLK_HZ * SEC_TIME_S;

   // Measuring interval and archive geometry, in minutes, seconds and entries
   localparam int INTERVAL_MIN = 15;
   localparam logic [15:0] INTERVAL_SEC = 16'(INTERVAL_MIN * 60);
   localparam logic [16:0] DAY_SEC = 17'h15180;
   localparam int DAY_DEPTH = 366;
   localparam int CAP_DEPTH = 7 * 24 * 60 / INTERVAL_MIN;

   // Register byte offsets
   localparam logic [7:0] A_SETPOINT = 8'h00;
   localparam logic [7:0] A_MAXCAP = 8'h04;
   localparam logic [7:0] A_BAND = 8'h08;
   localparam logic [7:0] A_WEIGHT = 8'h0C;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_EN_NORM = 8'h14;
   localparam logic [7:0] A_EN_PEAK = 8'h18;
   localparam logic [7:0] A_STG_SEL = 8'h1C;
   localparam logic [7:0] A_STG_LOAD = 8'h20;
   localparam logic [7:0] A_STG_MINOP = 8'h24;
   localparam logic [7:0] A_STG_MINSHED = 8'h28;
   localparam logic [7:0] A_STG_MAXSHED = 8'h2C;
   localparam logic [7:0] A_STG_CFG = 8'h30;
   localparam logic [7:0] A_SHED = 8'h34;
   localparam logic [7:0] A_STG_TMR = 8'h38;
   localparam logic [7:0] A_ARCH_SEL = 8'h3C;
   localparam logic [7:0] A_DAY_ARCH = 8'h40;
   localparam logic [7:0] A_CAP_ARCH = 8'h44;

   // Stage configuration field positions
   localparam int CFG_OUT = 0;
   localparam int CFG_FB = 1;
   localparam int CFG_DEM = 2;

   // Values after reset
   localparam logic [31:0] RST_SETPOINT = 32'hFFFFFFFF;
   localparam logic [31:0] RST_MAXCAP = 32'hFFFFFFFF;
   localparam logic [31:0] RST_WEIGHT = 32'h00000001;
   localparam logic [15:0] RST_TIMER = 16'hFFFF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHED = 3'b010,
      ST_LOAD = 3'b100
   } pds_state_type;
endpackage

// ===== pds_peak_demand_shedder.sv
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Functional notes
// R1 - Compare setpoint with actual power once per 15-minute interval, aligned to sync.
// R2 - Twenty stages in ascending priority; stage one is always shed first.
// R3 - Escalate to next higher stage until neutral band reached or highest stage shed.
// R4 - After restart run unsynchronised against maximum capacity until next sync pulse.
// R5 - Each stage holds a maximum shed load used to size the shed set.
// R6 - A stage with zero shed load is still shed in its priority order.
// R7 - Nonzero minimum operating time blocks re-shedding until the stage ran that long.
// R8 - A shed stage stays shed for its minimum shed time before reloading.
// R9 - Maximum shed timer expiry reloads the stage unconditionally; zero disables it.
// R10 - Every stage keeps its own independent timer.
// R11 - A stage sheds through its own output; no output assigned means never shed.
// R12 - Optional running feedback gates only that stage's shedding; unassigned means running.
// R13 - Optional demand input gates only that stage's reloading; unassigned means demand.
// R14 - Energy accumulates into separate normal and peak tariff totals.
// R15 - Keep one year of daily totals and one week of capacity values.
// R16 - Each feedback consumer has one input and one relay output.
// R17 - Meter pulses arrive at least 95 ms apart and 30 ms wide.
// R18 - Below the neutral band reload shed stages in descending priority.
// R19 - Actual power is the interval pulse count scaled by pulse weight.
module pds_peak_demand_shedder #(
   parameter int SEC_CYCLES = pds_pkg::SEC_CYC_DEF
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic METER_PULSE,
   input wire logic TARIFF_PEAK,
   input wire logic UTIL_SYNC,
   input wire logic [19:0] RUN_FB,
   input wire logic [19:0] DEMAND_IN,
   output logic [19:0] SHED_OUT
);
   function automatic logic sel_ok(input logic [4:0] s);
      return s <= pds_pkg::LAST_STG;
   endfunction

   logic [42:0] s1_reg, s2_reg;
   logic meter_prev_reg, sync_prev_reg;
   logic [19:0] run_s, dem_s;
   logic meter_s, peak_s, sync_s, meter_rise, sync_rise;
   logic [31:0] sec_cnt_reg;
   logic sec_tick_reg;
   logic [15:0] int_sec_reg;
   logic [23:0] pcnt_reg;
   logic [31:0] actual_reg;
   logic decide_reg, synced_reg, interval_end;
   logic [31:0] setpoint_reg, maxcap_reg, band_reg, weight_reg;
   logic [4:0] sel_reg;
   logic [9:0] arch_sel_reg;
   logic [15:0] stg_load_reg [0:19];
   logic [15:0] stg_minop_reg [0:19];
   logic [15:0] stg_minshed_reg [0:19];
   logic [15:0] stg_maxshed_reg [0:19];
   logic [2:0] stg_cfg_reg [0:19];
   logic [15:0] tmr_reg [0:19];
   logic [19:0] shed_reg, shed_prev_reg;
   logic [19:0] minop_ok, minshed_ok, max_exp, shed_ok, load_ok;
   logic [31:0] en_norm_reg, en_peak_reg, day_acc_reg, inc;
   logic [16:0] day_sec_reg;
   logic [8:0] day_idx_reg;
   logic [9:0] cap_idx_reg;
   logic day_end;
   logic [31:0] day_arch [0:pds_pkg::DAY_DEPTH-1];
   logic [31:0] cap_arch [0:pds_pkg::CAP_DEPTH-1];
   pds_pkg::pds_state_type state_reg;
   logic [4:0] idx_reg;
   logic [31:0] excess_reg, thr, cur_load;
   logic over, under;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   // Two-stage synchronisers for the meter, tariff, sync, feedback and demand inputs; the register bus is not synchronised
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s1_reg <= 43'h0;
         s2_reg <= 43'h0;
         meter_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         s1_reg <= {RUN_FB, DEMAND_IN, METER_PULSE, TARIFF_PEAK, UTIL_SYNC};
         s2_reg <= s1_reg;
         meter_prev_reg <= meter_s;
         sync_prev_reg <= sync_s;
      end
   end

   assign run_s = s2_reg[42:23];
   assign dem_s = s2_reg[22:3];
   assign meter_s = s2_reg[2];
   assign peak_s = s2_reg[1];
   assign sync_s = s2_reg[0];
   // Plain edge count; pulse spacing far above the clock period keeps this safe
   assign meter_rise = meter_s & ~meter_prev_reg; // R17
   assign sync_rise = sync_s & ~sync_prev_reg;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sec_cnt_reg <= 32'h0;
         sec_tick_reg <= 1'b0;
      end else if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
         sec_cnt_reg <= 32'h0;
         sec_tick_reg <= 1'b1;
      end else begin
         sec_cnt_reg <= sec_cnt_reg + 32'h1;
         sec_tick_reg <= 1'b0;
      end
   end

   // Sync pulse restarts the interval; until then it free-runs from restart
   assign interval_end = sync_rise | (sec_tick_reg && int_sec_reg == pds_pkg::INTERVAL_SEC - 16'h1);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         int_sec_reg <= 16'h0;
         pcnt_reg <= 24'h0;
         actual_reg <= 32'h0;
         decide_reg <= 1'b0;
         synced_reg <= 1'b0;
      end else begin
         decide_reg <= interval_end; // R1
         if (sync_rise) begin
            synced_reg <= 1'b1; // R4
         end
         if (interval_end) begin
            int_sec_reg <= 16'h0;
            pcnt_reg <= {23'h0, meter_rise};
            actual_reg <= 32'(pcnt_reg * weight_reg); // R19
         end else begin
            if (sec_tick_reg) begin
               int_sec_reg <= int_sec_reg + 16'h1;
            end
            pcnt_reg <= pcnt_reg + {23'h0, meter_rise}; // R19
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         setpoint_reg <= pds_pkg::RST_SETPOINT;
         maxcap_reg <= pds_pkg::RST_MAXCAP;
         band_reg <= 32'h0;
         weight_reg <= pds_pkg::RST_WEIGHT;
         sel_reg <= 5'h0;
         arch_sel_reg <= 10'h0;
         for (int i = 0; i < pds_pkg::NSTG; i++) begin
            stg_load_reg[i] <= 16'h0;
            stg_minop_reg[i] <= 16'h0;
            stg_minshed_reg[i] <= 16'h0;
            stg_maxshed_reg[i] <= 16'h0;
            stg_cfg_reg[i] <= 3'h0;
         end
      end else if (WR) begin
         unique case (ADDR)
            pds_pkg::A_SETPOINT: setpoint_reg <= WDATA;
            pds_pkg::A_MAXCAP: maxcap_reg <= WDATA;
            pds_pkg::A_BAND: band_reg <= WDATA;
            pds_pkg::A_WEIGHT: weight_reg <= WDATA;
            pds_pkg::A_STG_SEL: sel_reg <= WDATA[4:0];
            pds_pkg::A_ARCH_SEL: arch_sel_reg <= WDATA[9:0];
            pds_pkg::A_STG_LOAD: if (sel_ok(sel_reg)) stg_load_reg[sel_reg] <= WDATA[15:0]; // R5
            pds_pkg::A_STG_MINOP: if (sel_ok(sel_reg)) stg_minop_reg[sel_reg] <= WDATA[15:0];
            pds_pkg::A_STG_MINSHED: if (sel_ok(sel_reg)) stg_minshed_reg[sel_reg] <= WDATA[15:0];
            pds_pkg::A_STG_MAXSHED: if (sel_ok(sel_reg)) stg_maxshed_reg[sel_reg] <= WDATA[15:0];
            pds_pkg::A_STG_CFG: if (sel_ok(sel_reg)) stg_cfg_reg[sel_reg] <= WDATA[2:0]; // R16
            default: ;
         endcase
      end
   end

   assign inc = meter_rise ? weight_reg : 32'h0;
   assign day_end = sec_tick_reg && day_sec_reg == pds_pkg::DAY_SEC - 17'h1;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         en_norm_reg <= 32'h0;
         en_peak_reg <= 32'h0;
         day_acc_reg <= 32'h0;
         day_sec_reg <= 17'h0;
         day_idx_reg <= 9'h0;
         cap_idx_reg <= 10'h0;
      end else begin
         if (meter_rise && peak_s) begin
            en_peak_reg <= en_peak_reg + weight_reg; // R14
         end
         if (meter_rise && !peak_s) begin
            en_norm_reg <= en_norm_reg + weight_reg; // R14
         end
         if (day_end) begin
            day_sec_reg <= 17'h0;
            day_acc_reg <= inc;
            day_idx_reg <= (day_idx_reg == 9'(pds_pkg::DAY_DEPTH - 1)) ? 9'h0 : day_idx_reg + 9'h1;
         end else begin
            day_sec_reg <= day_sec_reg + {16'h0, sec_tick_reg};
            day_acc_reg <= day_acc_reg + inc;
         end
         if (decide_reg) begin
            cap_idx_reg <= (cap_idx_reg == 10'(pds_pkg::CAP_DEPTH - 1)) ? 10'h0 : cap_idx_reg + 10'h1;
         end
      end
   end

   // Archives are plain storage and are not cleared by reset
   always_ff @(posedge CLK) begin
      if (day_end) begin
         day_arch[day_idx_reg] <= day_acc_reg; // R15
      end
      if (decide_reg) begin
         cap_arch[cap_idx_reg] <= actual_reg; // R15
      end
   end

   // One timer per stage, restarted by any change of that stage's shed state
   for (genvar i = 0; i < pds_pkg::NSTG; i++) begin : g_stage
      // Timer restarts one cycle after a shed change; its count is stale until then
      assign minop_ok[i] = stg_minop_reg[i] == 16'h0
         || (!shed_prev_reg[i] && tmr_reg[i] >= stg_minop_reg[i]); // R7
      assign minshed_ok[i] = stg_minshed_reg[i] == 16'h0
         || (shed_prev_reg[i] && tmr_reg[i] >= stg_minshed_reg[i]); // R8
      assign max_exp[i] = shed_reg[i] && shed_prev_reg[i] && stg_maxshed_reg[i] != 16'h0
         && tmr_reg[i] >= stg_maxshed_reg[i]; // R9
      assign shed_ok[i] = !shed_reg[i] && stg_cfg_reg[i][pds_pkg::CFG_OUT] && minop_ok[i]
         && (!stg_cfg_reg[i][pds_pkg::CFG_FB] || run_s[i]); // R11 R12
      assign load_ok[i] = shed_reg[i] && minshed_ok[i]
         && (!stg_cfg_reg[i][pds_pkg::CFG_DEM] || dem_s[i]); // R13

      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            tmr_reg[i] <= pds_pkg::RST_TIMER;
            shed_prev_reg[i] <= 1'b0;
         end else begin
            shed_prev_reg[i] <= shed_reg[i];
            if (shed_reg[i] != shed_prev_reg[i]) begin
               tmr_reg[i] <= 16'h0; // R10
            end else if (sec_tick_reg && tmr_reg[i] != pds_pkg::RST_TIMER) begin
               tmr_reg[i] <= tmr_reg[i] + 16'h1;
            end
         end
      end

      a_maxshed_release: assert property (max_exp[i] |=> !shed_reg[i]) // R9
         else $error("stage not released at maximum shed time");
      a_no_output_idle: assert property (!stg_cfg_reg[i][pds_pkg::CFG_OUT] |=> !shed_reg[i]) // R11
         else $error("stage without output was shed");
      a_timer_restart: assert property ($changed(shed_reg[i]) |=> tmr_reg[i] == 16'h0) // R10
         else $error("stage timer not restarted on shed change");
   end

   assign thr = synced_reg ? setpoint_reg : maxcap_reg; // R4
   assign over = actual_reg > thr; // R1
   assign under = 33'(actual_reg) + 33'(band_reg) < 33'(thr); // R18
   assign cur_load = {16'h0, stg_load_reg[idx_reg]};

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_reg <= pds_pkg::ST_IDLE;
         idx_reg <= 5'h0;
         excess_reg <= 32'h0;
         shed_reg <= 20'h0;
      end else begin
         unique case (state_reg)
            pds_pkg::ST_IDLE: begin
               if (decide_reg && over) begin
                  state_reg <= pds_pkg::ST_SHED;
                  idx_reg <= 5'h0; // R2
                  excess_reg <= actual_reg - thr;
               end else if (decide_reg && under) begin
                  state_reg <= pds_pkg::ST_LOAD;
                  idx_reg <= pds_pkg::LAST_STG; // R18
               end
            end
            pds_pkg::ST_SHED: begin
               if (shed_ok[idx_reg]) begin
                  shed_reg[idx_reg] <= 1'b1; // R6
                  excess_reg <= (excess_reg > cur_load) ? excess_reg - cur_load : 32'h0; // R5
               end
               if (idx_reg == pds_pkg::LAST_STG || (shed_ok[idx_reg] && excess_reg <= cur_load)) begin
                  state_reg <= pds_pkg::ST_IDLE;
               end else begin
                  idx_reg <= idx_reg + 5'h1; // R3
               end
            end
            pds_pkg::ST_LOAD: begin
               if (load_ok[idx_reg]) begin
                  shed_reg[idx_reg] <= 1'b0; // R18
                  state_reg <= pds_pkg::ST_IDLE;
               end else if (idx_reg == 5'h0) begin
                  state_reg <= pds_pkg::ST_IDLE;
               end else begin
                  idx_reg <= idx_reg - 5'h1;
               end
            end
            default: state_reg <= pds_pkg::ST_IDLE;
         endcase
         // Forced releases override the scan in the same cycle
         for (int i = 0; i < pds_pkg::NSTG; i++) begin
            if (max_exp[i] || !stg_cfg_reg[i][pds_pkg::CFG_OUT]) begin
               shed_reg[i] <= 1'b0; // R9 R11
            end
         end
      end
   end

   assign SHED_OUT = shed_reg;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         unique case (ADDR)
            pds_pkg::A_SETPOINT: RDATA <= setpoint_reg;
            pds_pkg::A_MAXCAP: RDATA <= maxcap_reg;
            pds_pkg::A_BAND: RDATA <= band_reg;
            pds_pkg::A_WEIGHT: RDATA <= weight_reg;
            pds_pkg::A_STATUS: RDATA <= {23'h0, idx_reg, 3'(state_reg), synced_reg};
            pds_pkg::A_EN_NORM: RDATA <= en_norm_reg;
            pds_pkg::A_EN_PEAK: RDATA <= en_peak_reg;
            pds_pkg::A_STG_SEL: RDATA <= {27'h0, sel_reg};
            pds_pkg::A_STG_LOAD: RDATA <= sel_ok(sel_reg) ? {16'h0, stg_load_reg[sel_reg]} : 32'h0;
            pds_pkg::A_STG_MINOP: RDATA <= sel_ok(sel_reg) ? {16'h0, stg_minop_reg[sel_reg]} : 32'h0;
            pds_pkg::A_STG_MINSHED:
               RDATA <= sel_ok(sel_reg) ? {16'h0, stg_minshed_reg[sel_reg]} : 32'h0;
            pds_pkg::A_STG_MAXSHED:
               RDATA <= sel_ok(sel_reg) ? {16'h0, stg_maxshed_reg[sel_reg]} : 32'h0;
            pds_pkg::A_STG_CFG: RDATA <= sel_ok(sel_reg) ? {29'h0, stg_cfg_reg[sel_reg]} : 32'h0;
            pds_pkg::A_STG_TMR: RDATA <= sel_ok(sel_reg) ? {16'h0, tmr_reg[sel_reg]} : 32'h0;
            pds_pkg::A_SHED: RDATA <= {12'h0, shed_reg};
            pds_pkg::A_ARCH_SEL: RDATA <= {22'h0, arch_sel_reg};
            pds_pkg::A_DAY_ARCH: RDATA <= (arch_sel_reg < 10'(pds_pkg::DAY_DEPTH))
               ? day_arch[arch_sel_reg[8:0]] : 32'h0;
            pds_pkg::A_CAP_ARCH: RDATA <= (arch_sel_reg < 10'(pds_pkg::CAP_DEPTH))
               ? cap_arch[arch_sel_reg] : 32'h0;
            default: RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end

   a_interval_bound: assert property (int_sec_reg < pds_pkg::INTERVAL_SEC) // R1
      else $error("interval counter beyond interval length");
   a_first_stage: assert property ((state_reg == pds_pkg::ST_IDLE && decide_reg && over) // R2
      |=> state_reg == pds_pkg::ST_SHED && idx_reg == 5'h0)
      else $error("shed scan did not start at stage one");
   a_escalate_next: assert property ((state_reg == pds_pkg::ST_SHED && !shed_ok[idx_reg] // R3
      && idx_reg != pds_pkg::LAST_STG) |=> idx_reg == $past(idx_reg) + 5'h1)
      else $error("escalation skipped a stage");
   a_unsync_hold: assert property ((!synced_reg && !sync_rise) |=> !synced_reg) // R4
      else $error("synchronised without sync pulse");
   a_zero_load: assert property ((state_reg == pds_pkg::ST_SHED && shed_ok[idx_reg] // R6
      && stg_load_reg[idx_reg] == 16'h0 && idx_reg != pds_pkg::LAST_STG)
      |=> shed_reg[$past(idx_reg)] && state_reg == pds_pkg::ST_SHED)
      else $error("zero-load stage not shed in order");
   a_minop_block: assert property ((state_reg == pds_pkg::ST_SHED && !minop_ok[idx_reg] // R7
      && !shed_reg[idx_reg]) |=> !shed_reg[$past(idx_reg)])
      else $error("stage shed before minimum operating time");
   a_minshed_hold: assert property ((state_reg == pds_pkg::ST_LOAD && shed_reg[idx_reg] // R8
      && !minshed_ok[idx_reg] && !max_exp[idx_reg]
      && stg_cfg_reg[idx_reg][pds_pkg::CFG_OUT]) |=> shed_reg[$past(idx_reg)])
      else $error("stage reloaded before minimum shed time");
   a_fb_gate: assert property ((state_reg == pds_pkg::ST_SHED && !shed_reg[idx_reg] // R12
      && stg_cfg_reg[idx_reg][pds_pkg::CFG_FB] && !run_s[idx_reg]) |=> !shed_reg[$past(idx_reg)])
      else $error("stopped consumer was shed");
   a_demand_gate: assert property ((state_reg == pds_pkg::ST_LOAD && shed_reg[idx_reg] // R13
      && stg_cfg_reg[idx_reg][pds_pkg::CFG_DEM] && !dem_s[idx_reg] && !max_exp[idx_reg]
      && stg_cfg_reg[idx_reg][pds_pkg::CFG_OUT]) |=> shed_reg[$past(idx_reg)])
      else $error("stage reloaded without demand");
   a_tariff_split: assert property ((meter_rise && peak_s) // R14
      |=> en_peak_reg == $past(en_peak_reg) + $past(weight_reg) && $stable(en_norm_reg))
      else $error("peak energy not accumulated separately");

   c_shed_scan: cover property (state_reg == pds_pkg::ST_SHED ##1 state_reg == pds_pkg::ST_IDLE);
   c_load_scan: cover property (state_reg == pds_pkg::ST_LOAD && load_ok[idx_reg]);
   c_sync_align: cover property (!synced_reg ##1 synced_reg);
   c_max_expiry: cover property (|max_exp);
endmodule // pds_peak_demand_shedder

// ===== pds_far_side.sv
`timescale 1ns/10ps
module pds_far_side (
   input wire logic clk,
   input wire logic [19:0] shed_out,
   input wire logic [19:0] run_mask,
   input wire logic [19:0] dem_mask,
   output logic meter_pulse,
   output logic util_sync,
   output logic [19:0] run_fb,
   output logic [19:0] demand_in
);
   initial begin
      meter_pulse = 1'b0;
      util_sync = 1'b0;
   end

   // A shed consumer stops running, so its feedback drops with the relay
   assign run_fb = run_mask & ~shed_out;
   assign demand_in = dem_mask;

   // With a 10-cycle second, 3 high and 6 low keeps both the width and spacing floors
   task automatic send_pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         meter_pulse <= 1'b1;
         repeat (3) @(posedge clk);
         meter_pulse <= 1'b0;
         repeat (5) @(posedge clk);
      end
   endtask

   task automatic sync_pulse();
      @(posedge clk);
      util_sync <= 1'b1;
      repeat (4) @(posedge clk);
      util_sync <= 1'b0;
   endtask
endmodule // pds_far_side

// ===== pds_peak_demand_shedder_tb.sv
`timescale 1ns/10ps
module pds_peak_demand_shedder_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic tariff_peak = 1'b0;
   logic meter_pulse, util_sync;
   logic [19:0] run_fb, demand_in, shed_out;
   logic [19:0] run_mask = 20'h00000;
   logic [19:0] dem_mask = 20'h00000;
   logic [19:0] exp_shed;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int ld [20];
   logic [2:0] cfg [20];
   int n, n1, stop_idx;

   initial begin
      forever #25 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   pds_peak_demand_shedder #(.SEC_CYCLES(10)) DUT (
      .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .METER_PULSE(meter_pulse), .TARIFF_PEAK(tariff_peak),
      .UTIL_SYNC(util_sync), .RUN_FB(run_fb), .DEMAND_IN(demand_in), .SHED_OUT(shed_out)
   );

   pds_far_side far (
      .clk(clk), .shed_out(shed_out), .run_mask(run_mask), .dem_mask(dem_mask),
      .meter_pulse(meter_pulse), .util_sync(util_sync), .run_fb(run_fb),
      .demand_in(demand_in)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Excess stays odd and loads even, so coverage never ties exactly
   function automatic logic [19:0] shed_calc(input logic [19:0] cur, input int excess);
      int acc;
      acc = 0;
      stop_idx = 19;
      for (int i = 0; i < 20; i++) begin
         if (!cur[i] && cfg[i][0] && (!cfg[i][1] || run_mask[i])) begin
            cur[i] = 1'b1;
            acc += ld[i];
            if (acc >= excess) begin
               stop_idx = i;
               break;
            end
         end
      end
      return cur;
   endfunction

   function automatic logic [19:0] reload_calc(input logic [19:0] cur);
      for (int i = 19; i >= 0; i--) begin
         if (cur[i] && (!cfg[i][2] || dem_mask[i])) begin
            cur[i] = 1'b0;
            break;
         end
      end
      return cur;
   endfunction

   task automatic shed_chk(input logic [19:0] exp);
      #1;
      chk({12'h000, shed_out}, {12'h000, exp});
      rd_chk(pds_pkg::A_SHED, {12'h000, exp});
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h1bb2ae5c));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      run_mask <= 20'($urandom) & 20'hFFFEF;
      dem_mask <= 20'($urandom);
      tariff_peak <= 1'($urandom);
      rd_chk(pds_pkg::A_SETPOINT, pds_pkg::RST_SETPOINT);
      rd_chk(pds_pkg::A_MAXCAP, pds_pkg::RST_MAXCAP);
      rd_chk(pds_pkg::A_WEIGHT, pds_pkg::RST_WEIGHT);
      rd_chk(pds_pkg::A_STATUS, 32'h00000002);
      rd_chk(pds_pkg::A_STG_TMR, {16'h0000, pds_pkg::RST_TIMER});
      wr_reg(8'hFC, 32'h12345678);
      rd_chk(8'hFC, 32'h00000000);
      wr_reg(pds_pkg::A_STG_SEL, 32'd20);
      rd_chk(pds_pkg::A_STG_LOAD, 32'h00000000);
      for (int i = 0; i < 20; i++) begin
         ld[i] = (i == 1) ? 0 : 2 * (1 + int'($urandom % 10));
         cfg[i] = 3'h1 | ((i == 4) ? 3'h2 : 3'h0) | ((i >= 10 && i % 2 == 0) ? 3'h4 : 3'h0);
         if (i == 5) cfg[i] = 3'h0;
         wr_reg(pds_pkg::A_STG_SEL, 32'(i));
         wr_reg(pds_pkg::A_STG_LOAD, 32'(ld[i]));
         wr_reg(pds_pkg::A_STG_CFG, {29'h0, cfg[i]});
      end
      // Only the capacity limit applies before the first sync
      wr_reg(pds_pkg::A_MAXCAP, 32'd10);
      n1 = 11 + 2 * int'($urandom % 10);
      far.send_pulses(n1);
      while (cyc < 9200) @(posedge clk);
      exp_shed = shed_calc(20'h00000, n1 - 10);
      shed_chk(exp_shed);
      wr_reg(pds_pkg::A_SETPOINT, 32'h0000000A);
      wr_reg(pds_pkg::A_WEIGHT, 32'h00000003);
      // Odd count times three keeps the excess odd
      n = 5 + 2 * int'($urandom % 5);
      far.send_pulses(n);
      far.sync_pulse();
      repeat (60) @(posedge clk);
      exp_shed = shed_calc(exp_shed, 3 * n - 10);
      shed_chk(exp_shed);
      rd_chk(pds_pkg::A_STATUS, 32'(stop_idx * 16 + 3));
      far.sync_pulse();
      repeat (60) @(posedge clk);
      exp_shed = reload_calc(exp_shed);
      shed_chk(exp_shed);
      wr_reg(pds_pkg::A_STG_SEL, 32'd0);
      wr_reg(pds_pkg::A_STG_MAXSHED, 32'd1);
      repeat (40) @(posedge clk);
      exp_shed[0] = 1'b0;
      shed_chk(exp_shed);
      rd_chk(pds_pkg::A_EN_PEAK, tariff_peak ? 32'(n1 + 3 * n) : 32'h00000000);
      rd_chk(pds_pkg::A_EN_NORM, tariff_peak ? 32'h00000000 : 32'(n1 + 3 * n));
      rd_chk(pds_pkg::A_CAP_ARCH, 32'(n1));
      wr_reg(pds_pkg::A_ARCH_SEL, 32'h00000001);
      rd_chk(pds_pkg::A_CAP_ARCH, 32'(3 * n));
      // Restart in mid-run falls back to unsynchronised operation
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      shed_chk(20'h00000);
      rd_chk(pds_pkg::A_STATUS, 32'h00000002);
      print_verdict();
   end
endmodule // pds_peak_demand_shedder_tb
